/* File: logic/drfa_regs.vh */
`ifndef DRFA_REGS_VH
`define DRFA_REGS_VH
// ----------------------------------------
// timing, in ns and derived cycles at 200 MHz
// ----------------------------------------
`define DRFA_CLK_PERIOD_NS   5
`define DRFA_REF_SLOW_NS     15000
`define DRFA_REF_FAST_NS     13000
`define DRFA_REF_SLOW_CYC    (`DRFA_REF_SLOW_NS / `DRFA_CLK_PERIOD_NS)
`define DRFA_REF_FAST_CYC    (`DRFA_REF_FAST_NS / `DRFA_CLK_PERIOD_NS)
// ----------------------------------------
// refresh and access defaults
// ----------------------------------------
`define DRFA_RAS_LOW_CYC     4
`define DRFA_PRECHG_CYC      2
`define DRFA_WAIT_STATES     1
`define DRFA_ROW_BITS        10
`define DRFA_ADDR_BITS       24
`endif

/* File: logic/drfa_ctrl.v */
`include "drfa_regs.vh"
module drfa_ctrl #(
  parameter REF_SLOW_CYC = `DRFA_REF_SLOW_CYC,
  parameter REF_FAST_CYC = `DRFA_REF_FAST_CYC,
  parameter RAS_LOW_CYC  = `DRFA_RAS_LOW_CYC,
  parameter PRECHG_CYC   = `DRFA_PRECHG_CYC,
  parameter ROW_BITS     = `DRFA_ROW_BITS,
  parameter ADDR_BITS    = `DRFA_ADDR_BITS
) (
  input  wire                 clk_i,                      // 200 MHz clock
  input  wire                 rst_n_i,                    // sync reset, low
  input  wire                 access_mode_i,              // 0 latch enable, 1 addr strobe
  input  wire                 ack_polarity_bit_i,         // 1 transfer ack, 0 wait
  input  wire                 addr_latch_en_i,            // address latching enabled
  input  wire                 fast_interval_i,            // 1 selects 13 us interval
  input  wire [3:0]           wait_states_i,              // hold-off delay in edges
  input  wire                 chip_select_n_i,            // chip select, low
  input  wire                 address_strobe_in_i,        // strobe, active as per mode
  input  wire                 access_request_in_n_i,      // access request, low
  input  wire [ADDR_BITS-1:0] addr_i,                     // bank/row/column address
  input  wire                 stall_extend_in_i,          // stretches completion
  input  wire                 ext_refresh_req_in_n_i,     // external refresh, low
  input  wire                 internal_refresh_off_in_n_i,// internal refresh off, low
  input  wire                 refresh_extend_in_i,        // stretches refresh
  output reg                  refresh_active_out_n_o,     // refresh in progress, low
  output reg                  refresh_due_out_n_o,        // refresh due, low
  output reg                  row_strobe_n_o,             // row strobe, low
  output reg                  transfer_ack_out_o,         // hold-off: wait or ack
  output reg  [ADDR_BITS-1:0] addr_latched_o,             // captured address
  output reg  [ROW_BITS-1:0]  refresh_row_o               // refresh row address
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE   = 3'h0;
  localparam ST_RF_PRE = 3'h1;
  localparam ST_RF_RAS = 3'h2;
  localparam ST_RF_END = 3'h3;
  localparam ST_ACC    = 3'h4;
  localparam ST_PRECHG = 3'h5;

  // ----------------------------------------
  // pin decodes, active high inside
  // ----------------------------------------
  wire ext_req    = ~ext_refresh_req_in_n_i;
  wire int_off    = ~internal_refresh_off_in_n_i;
  wire cs         = ~chip_select_n_i;
  wire access_request_in       = ~access_request_in_n_i;
  wire strobe_act = access_mode_i ? ~address_strobe_in_i : address_strobe_in_i;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [2:0]           state_ff;
  reg [2:0]           nxt_state;
  reg [15:0]          intv_ff;
  reg                 rf_due_ff;
  reg                 ext_req_ff;
  reg                 strobe_ff;
  reg                 pend_ff;
  reg [7:0]           cnt_ff;
  reg [7:0]           nxt_cnt;
  reg [4:0]           ws_ff;
  reg                 done_ff;

  wire ext_rise    = ext_req & ~ext_req_ff;
  // held request keeps refreshing back to back while internal refresh is off
  wire ext_rf_req  = ext_req & int_off;
  wire int_rf_req  = rf_due_ff & ~int_off;
  wire rf_req      = ext_rf_req | int_rf_req;
  wire acc_req     = pend_ff & cs & access_request_in;
  // counter clears on its last count, so one period is exactly the count
  wire intv_last_fast = (intv_ff >= REF_FAST_CYC[15:0] - 16'h0001);
  wire intv_last_slow = (intv_ff >= REF_SLOW_CYC[15:0] - 16'h0001);
  wire intv_end       = fast_interval_i ? intv_last_fast : intv_last_slow;

  // ----------------------------------------
  // strobe edges, meaning set by access mode
  // ----------------------------------------
  // mode 0 latch enable drops; mode 1 address strobe goes low
  wire strobe_rise = ~strobe_ff & strobe_act;
  wire strobe_drop = strobe_ff & ~strobe_act;
  wire strobe_fall = access_mode_i ? strobe_rise : strobe_drop;

  // ----------------------------------------
  // refresh interval counter
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      intv_ff    <= 16'h0000;
      ext_req_ff <= 1'b0;
    end else begin
      ext_req_ff <= ext_req;
      intv_ff    <= intv_end ? 16'h0000 : intv_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // refresh due flag
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i)
      rf_due_ff <= 1'b0;
    // a new interval end wins over the clear by a started refresh
    else if (intv_end)
      rf_due_ff <= 1'b1;
    else if (state_ff == ST_RF_PRE && !ext_rf_req)
      rf_due_ff <= 1'b0;
  end

  // ----------------------------------------
  // access pending latch
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i)
      strobe_ff <= 1'b0;
    else
      strobe_ff <= strobe_act;
  end

  always @(posedge clk_i) begin
    if (!rst_n_i)
      pend_ff <= 1'b0;
    else if (strobe_act && cs)
      pend_ff <= 1'b1;
    else if (state_ff == ST_ACC && !access_request_in)
      pend_ff <= 1'b0;
  end

  // ----------------------------------------
  // address capture
  // ----------------------------------------
  // no chip select needed: the latch follows the strobe edge while latching is enabled
  always @(posedge clk_i) begin
    if (!rst_n_i)
      addr_latched_o <= {ADDR_BITS{1'b0}};
    else if (strobe_fall && addr_latch_en_i)
      addr_latched_o <= addr_i;
  end

  // ----------------------------------------
  // arbiter and strobe sequencer
  // ----------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff == 8'h00) ? 8'h00 : cnt_ff - 8'h01;
    case (state_ff)
      ST_IDLE: begin
        // refresh has priority; an access stays pending meanwhile
        if (rf_req) begin
          nxt_state = ST_RF_PRE;
        end else if (acc_req) begin
          nxt_state = ST_ACC;
        end
      end
      ST_RF_PRE: begin
        nxt_state = ST_RF_RAS;
        nxt_cnt   = RAS_LOW_CYC[7:0] - 8'h01;
      end
      ST_RF_RAS: begin
        // extend stretches the low time by whole clocks
        if (cnt_ff == 8'h00 && !refresh_extend_in_i)
          nxt_state = ST_RF_END;
        else if (cnt_ff == 8'h00)
          nxt_cnt = 8'h00;
      end
      ST_RF_END: begin
        nxt_state = ST_PRECHG;
        nxt_cnt   = PRECHG_CYC[7:0] - 8'h01;
      end
      ST_ACC: begin
        if (!access_request_in) begin
          nxt_state = ST_PRECHG;
          nxt_cnt   = PRECHG_CYC[7:0] - 8'h01;
        end
      end
      ST_PRECHG: begin
        // precharge guards the next row strobe of either owner
        if (cnt_ff == 8'h00)
          nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------
  // refresh row counter
  // ----------------------------------------
  // clear only on the edge, so a held request clears once
  wire row_clr  = ext_rise & ~int_off;
  wire row_step = (state_ff == ST_RF_END);

  always @(posedge clk_i) begin
    if (!rst_n_i)
      refresh_row_o <= {ROW_BITS{1'b0}};
    else if (row_clr)
      refresh_row_o <= {ROW_BITS{1'b0}};
    else if (row_step)
      refresh_row_o <= refresh_row_o + {{(ROW_BITS-1){1'b0}}, 1'b1};
  end

  // ----------------------------------------
  // hold-off with wait states
  // ----------------------------------------
  // the count freezes while stalled, it is never reloaded
  wire ws_reached = (ws_ff >= {1'b0, wait_states_i});

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ws_ff   <= 5'h00;
      done_ff <= 1'b0;
    end else if (state_ff != ST_ACC) begin
      ws_ff   <= 5'h00;
      done_ff <= 1'b0;
    end else if (stall_extend_in_i) begin
      ws_ff <= ws_ff;
    end else if (!ws_reached) begin
      ws_ff <= ws_ff + 5'h01;
    end else begin
      done_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // next values of the outputs
  // ----------------------------------------
  // refresh active and row strobe are decoded from the next state so both move with the state
  wire nxt_rf_active = (nxt_state == ST_RF_PRE) ||
                       (nxt_state == ST_RF_RAS) ||
                       (nxt_state == ST_RF_END);
  wire nxt_row_low   = (nxt_state == ST_RF_RAS) ||
                       (nxt_state == ST_ACC);
  wire acc_done      = (state_ff == ST_ACC) && done_ff;
  // a late stall still holds off an ack not yet given
  wire ack_give      = acc_done && (!stall_extend_in_i || !transfer_ack_out_o);
  wire cpu_waiting   = pend_ff && cs && !acc_done;

  // ----------------------------------------
  // refresh active and refresh due outputs
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      refresh_active_out_n_o <= 1'b1;
      refresh_due_out_n_o    <= 1'b1;
    end else begin
      // held from the pre-state until all row strobes are high again
      refresh_active_out_n_o <= ~nxt_rf_active;
      refresh_due_out_n_o    <= ~rf_due_ff;
    end
  end

  // ----------------------------------------
  // row strobe output
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i)
      row_strobe_n_o <= 1'b1;
    else
      row_strobe_n_o <= ~nxt_row_low;
  end

  // ----------------------------------------
  // hold-off output, polarity fixed by programming
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i)
      transfer_ack_out_o <= 1'b1;
    else if (ack_polarity_bit_i)
      transfer_ack_out_o <= ~ack_give;
    else
      transfer_ack_out_o <= ~cpu_waiting;
  end

endmodule

/* File: sim/drfa_ctrl_monitor.sv */
module drfa_ctrl_monitor (
  input wire clk_i, rst_n_i, ack_polarity_bit_i, chip_select_n_i,  // watched inputs
  input wire access_request_in_n_i, stall_extend_in_i, ext_refresh_req_in_n_i,
  input wire internal_refresh_off_in_n_i, refresh_extend_in_i,
  input wire refresh_active_out_n_o, row_strobe_n_o, transfer_ack_out_o  // watched outputs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire rf = !refresh_active_out_n_o;
  wire ak = ack_polarity_bit_i;
  a_refresh_active_out_lead: assert property ($fell(row_strobe_n_o) && rf |-> !$past(refresh_active_out_n_o))
    else $error("refresh flag late");
  a_refresh_active_out_trail: assert property ($rose(refresh_active_out_n_o) |-> row_strobe_n_o)
    else $error("refresh flag cleared early");
  a_access_cause: assert property ($fell(row_strobe_n_o) && !rf
    |-> $past(!access_request_in_n_i && !chip_select_n_i)) else $error("access without request");
  a_access_request_in_end: assert property ($rose(access_request_in_n_i) && !rf |-> ##[0:2] row_strobe_n_o)
    else $error("row strobe held");
  a_ack_delay: assert property ($fell(row_strobe_n_o) && !rf && ak |-> transfer_ack_out_o)
    else $error("ack too early");
  a_ack_in_access: assert property (ak && $fell(transfer_ack_out_o) |-> !row_strobe_n_o && !rf)
    else $error("ack outside access");
  a_stall_freeze: assert property (ak && stall_extend_in_i && transfer_ack_out_o
    && !row_strobe_n_o |=> transfer_ack_out_o) else $error("ack during stall");
  a_rext_hold: assert property (rf && refresh_extend_in_i && !row_strobe_n_o |=> !row_strobe_n_o)
    else $error("refresh not extended");
  a_no_internal: assert property ($fell(refresh_active_out_n_o) && !internal_refresh_off_in_n_i
    && $past(!internal_refresh_off_in_n_i, 8)
    |-> $past(!ext_refresh_req_in_n_i) || $past(!ext_refresh_req_in_n_i, 2))
    else $error("internal refresh while off");
endmodule
bind drfa_ctrl drfa_ctrl_monitor i_mon (.*);

/* File: sim/drfa_cpu_model.sv */
module drfa_cpu_model (
  input  wire         clk_i,               // controller clock
  input  wire         row_strobe_n_o,      // row strobe seen
  input  wire         transfer_ack_out_o,  // hold-off seen
  output logic        stb_o = 1'b0,        // strobe, mode dependent
  output logic        cs_n_o = 1'b1,       // chip select
  output logic        access_request_in_n_o = 1'b1,     // access request
  output logic        stall_o = 1'b0,      // wait extend
  output logic [23:0] adr_o = 24'h0        // address
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic run(input logic m, sel, input logic [23:0] a, input int s, output int w, lat);
    @(posedge clk_i);
    stb_o <= m;  // idle level of the strobe in this mode
    @(posedge clk_i);
    stb_o <= !m;
    cs_n_o <= !sel;
    adr_o <= a;
    @(posedge clk_i);
    access_request_in_n_o <= 1'b0;
    @(posedge clk_i);
    stb_o <= m;
    w = 0;
    lat = 0;
    while (row_strobe_n_o && w < 60) begin
      @(negedge clk_i);
      w++;
    end
    while (sel && transfer_ack_out_o && lat < 60) begin
      @(posedge clk_i);
      stall_o <= lat < s;
      @(negedge clk_i);
      lat++;
    end
    @(posedge clk_i);
    access_request_in_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    stall_o <= 1'b0;
    adr_o <= ~a;  // released bus shows no stale address
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* File: sim/tb_drfa_ctrl.sv */
module tb_drfa_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CS = 400, CF = 300;
  logic clk_i = 0, rst_n_i = 0, mode = 0, fast = 0, ext_n = 1, off_n = 1, rext = 0, m;
  logic [3:0] ws = 4'h1;
  logic rp = 1'b1;  // refresh flag seen at the last negedge
  logic [23:0] a;
  wire stb, cs_n, access_request_in_n, stall, refresh_active_out_n, due_n, row_n, ack;
  wire [23:0] adr, adr_l;
  wire [9:0] rrow;
  int err_count = 0, n_checks = 0, lat, w, k, c, s, v;
  drfa_ctrl #(.REF_SLOW_CYC(CS), .REF_FAST_CYC(CF)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .access_mode_i(mode), .ack_polarity_bit_i(1'b1), .addr_latch_en_i(1'b1),
    .fast_interval_i(fast), .wait_states_i(ws), .chip_select_n_i(cs_n),
    .address_strobe_in_i(stb), .access_request_in_n_i(access_request_in_n), .addr_i(adr),
    .stall_extend_in_i(stall), .ext_refresh_req_in_n_i(ext_n),
    .internal_refresh_off_in_n_i(off_n), .refresh_extend_in_i(rext),
    .refresh_active_out_n_o(refresh_active_out_n), .refresh_due_out_n_o(due_n), .row_strobe_n_o(row_n),
    .transfer_ack_out_o(ack), .addr_latched_o(adr_l), .refresh_row_o(rrow));
  drfa_cpu_model i_cpu (.clk_i(clk_i), .row_strobe_n_o(row_n), .transfer_ack_out_o(ack),
    .stb_o(stb), .cs_n_o(cs_n), .access_request_in_n_o(access_request_in_n), .stall_o(stall), .adr_o(adr));
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
  task automatic cmp(input logic [23:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // counts refresh starts over n cycles
  task automatic cyc(input int n, output int f);
    f = 0;
    repeat (n) begin
      @(negedge clk_i);
      f += int'(rp & !refresh_active_out_n);
      rp = refresh_active_out_n;
    end
  endtask
  task automatic rst_due(input logic f, input int ce);
    @(posedge clk_i);
    rst_n_i <= 0;
    fast <= f;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1;
    @(negedge clk_i);
    cmp({refresh_active_out_n, due_n, row_n, ack, rrow}, 14'h3C00);
    cmp(adr_l, 24'h0);
    rp = 1'b1;
    c = 1;
    while (due_n && c < 2000) begin
      @(negedge clk_i);
      c++;
    end
    cmp(c >= ce - 3 && c <= ce + 3, 1);
  endtask
  task complete_run();
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(10212));
    rst_due(0, CS);
    cyc(30, k);
    cmp(k, 1);
    cmp(rrow, 1);
    @(posedge clk_i) ext_n <= 0;
    repeat (2) @(posedge clk_i);
    ext_n <= 1;
    cyc(6, k);
    cmp({k[0], rrow}, 0);
    rst_due(1, CF);
    cyc(30, k);
    @(posedge clk_i) off_n <= 0;
    cyc(10, k);
    a = rrow;
    @(posedge clk_i) ext_n <= 0;
    cyc(40, k);
    @(posedge clk_i) rext <= 1;
    cyc(5, c);
    @(posedge clk_i) rext <= 0;
    cyc(40, s);
    @(posedge clk_i) ext_n <= 1;
    k += c + s;
    cyc(20, c);
    k += c;
    cmp(rrow, 10'(a + k));
    cmp(k > 3, 1);
    cyc(700, k);
    cmp(k, 0);
    for (int i = 0; i < 12; i++) begin
      a = 24'($urandom);
      s = $urandom % 4;
      v = 1 + $urandom % 6;
      m = 1'($urandom);
      @(posedge clk_i);
      mode <= m;
      ws <= 4'(v);
      i_cpu.run(m, i != 5, a, s, w, lat);
      if (i == 5) cmp(w, 60);
      else begin
        cmp(adr_l, a);
        cmp(lat, v + s + 2);
      end
    end
    complete_run();
  end
endmodule
